// ### src/ist_pkg.sv
package ist_pkg;
  // ----------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_OWN_ADDR = 2'h3;

  // control register bit positions
  localparam int CTRL_STEP = 7;
  localparam int CTRL_ACK = 6;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_EN = 2;
  // own address: general call enable in bit 0
  localparam int OWN_GCE = 0;
  // status code occupies bits 7:3, prescaler bits below read zero
  localparam int STAT_LSB = 3;

  // ----------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] ADDR_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // status codes, prescaler bits masked to zero
  localparam logic [7:0] STS_OWN_READ = 8'ha8;
  localparam logic [7:0] STS_ARB_READ = 8'hb0;
  localparam logic [7:0] STS_DATA_ACK = 8'hb8;
  localparam logic [7:0] STS_DATA_NACK = 8'hc0;
  localparam logic [7:0] STS_LAST_ACK = 8'hc8;
  localparam logic [7:0] STS_NONE = 8'hf8;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WAIT,
    ST_TX,
    ST_TX_ACK,
    ST_IGNORE
  } ist_state_t;
endpackage

// ### src/ist_slave_tx.sv
// Operation
// - match upper seven own-address bits against address
// - general call 0x00 only when enable bit set
// - read direction enters transmitter, write enters receiver
// - set step flag, post status after address
// - own address read acknowledged gives 0xA8
// - lost arbitration then own read gives 0xB0
// - data byte acknowledged gives 0xB8
// - software loads byte, clears step; byte sent
// - ack enable zero marks byte as final
// - final byte then 0xC0 on nack, 0xC8 ack
// - after final byte release SDA, master reads ones
// - nack gives 0xC0, no further data transfer
// - from 0xC0 with ack off, recognise nothing
// - from 0xC0 with ack on, recognise again
// - start request from 0xC0 issues START when free
// - ack enable zero ignores address, keeps monitoring
// - deep sleep still matches address with ack on
// - wake on sleep match, hold SCL until step cleared
// - data register not refreshed from bus on wake
// - final byte acknowledged gives 0xC8, no transfer
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ist_slave_tx
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic arb_lost_i,
  input wire logic sleep_i,
  output logic wake_o,
  output logic start_issue_o,
  output logic slave_tx_mode_o,
  output logic slave_rx_mode_o
);
  import ist_pkg::*;
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  ist_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic sda_oe_n_ff, nxt_sda_oe_n;
  logic scl_oe_n_ff, nxt_scl_oe_n;
  logic [7:0] status_ff, nxt_status;
  logic last_ff, nxt_last;
  logic mack_ff, nxt_mack;
  logic hw_set;
  logic step_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] own_ff;
  logic [7:0] data_ff;
  logic [7:0] rdata_ff;
  logic [1:0] pin_m_ff, pin_s_ff, pin_d_ff;
  logic busy_ff;
  logic start_pend_ff;
  logic start_issue_ff;
  logic wake_ff;
  logic rx_mode_ff;
  logic rx_enter;
  // ----------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------
  wire wr_ctrl = wr_i && (addr_i == REG_CTRL);
  wire wr_data = wr_i && (addr_i == REG_DATA);
  wire wr_own = wr_i && (addr_i == REG_OWN_ADDR);
  // writing one to the step flag clears it
  wire sw_clr = wr_ctrl && wdata_i[CTRL_STEP];
  wire ack_en = ctrl_ff[CTRL_ACK];
  wire iface_en = ctrl_ff[CTRL_EN];
  wire [7:0] ctrl_rd = {step_ff, ctrl_ff[CTRL_STEP-1:0]};
  wire [7:0] status_rd = {status_ff[7:STAT_LSB], 3'h0};
  wire [7:0] rd_mux = (addr_i == REG_CTRL) ? ctrl_rd : (addr_i == REG_STATUS) ? status_rd :
                      (addr_i == REG_DATA) ? data_ff : own_ff;
  // ----------------------------------------------------------
  // bus line conditioning
  // ----------------------------------------------------------
  // bit 1 is scl, bit 0 is sda; pin_m is read by pin_s only
  wire scl_s = pin_s_ff[1];
  wire sda_s = pin_s_ff[0];
  wire scl_d = pin_d_ff[1];
  wire sda_d = pin_d_ff[0];
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_det = scl_s && scl_d && sda_d && !sda_s;
  wire stop_det = scl_s && scl_d && !sda_d && sda_s;
  // ----------------------------------------------------------
  // address match
  // ----------------------------------------------------------
  // ack enable gates both own and general call matches
  wire own_hit = (shift_ff[7:1] == own_ff[7:1]);
  wire gc_hit = (shift_ff[7:1] == GEN_CALL_ADDR) && own_ff[OWN_GCE];
  wire match_w = iface_en && ack_en && (own_hit || gc_hit);
  wire dir_rd = shift_ff[0];
  wire addr_done = (state_ff == ST_ADDR) && scl_fall && (cnt_ff == ADDR_BITS);
  wire end_state = (status_ff == STS_DATA_NACK) || (status_ff == STS_LAST_ACK);
  // ----------------------------------------------------------
  // byte and bit sequencer
  // ----------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_scl_oe_n = scl_oe_n_ff;
    nxt_status = status_ff;
    nxt_last = last_ff;
    nxt_mack = mack_ff;
    hw_set = 1'b0;
    rx_enter = 1'b0;
    if (!iface_en)
    begin
      nxt_state = ST_IDLE;
      nxt_sda_oe_n = 1'b1;
      nxt_scl_oe_n = 1'b1;
    end
    else if (stop_det)
    begin
      nxt_state = ST_IDLE;
      nxt_sda_oe_n = 1'b1;
    end
    else if (start_det)
    begin
      nxt_state = ST_ADDR; // a repeated start restarts address capture
      nxt_cnt = CNT_ZERO;
      nxt_sda_oe_n = 1'b1;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE, ST_IGNORE:
        begin
          nxt_sda_oe_n = 1'b1;
        end
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + CNT_ONE;
          end
          else if (addr_done)
          begin
            if (match_w && dir_rd)
            begin
              nxt_state = ST_ADDR_ACK;
              nxt_sda_oe_n = 1'b0;
            end
            else
            begin
              rx_enter = match_w;
              nxt_state = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            nxt_sda_oe_n = 1'b1;
            nxt_scl_oe_n = 1'b0;
            hw_set = 1'b1;
            nxt_status = arb_lost_i ? STS_ARB_READ : STS_OWN_READ;
            nxt_state = ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // scl held low until software releases the next byte
          if (sw_clr && step_ff)
          begin
            nxt_shift = data_ff;
            nxt_sda_oe_n = data_ff[7];
            nxt_last = !wdata_i[CTRL_ACK];
            nxt_cnt = CNT_ZERO;
            nxt_scl_oe_n = 1'b1;
            nxt_state = ST_TX;
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_ff == LAST_BIT)
            begin
              nxt_sda_oe_n = 1'b1;
              nxt_state = ST_TX_ACK;
            end
            else
            begin
              nxt_cnt = cnt_ff + CNT_ONE;
              nxt_shift = {shift_ff[6:0], 1'b1};
              nxt_sda_oe_n = shift_ff[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            nxt_mack = !sda_s;
          end
          else if (scl_fall)
          begin
            hw_set = 1'b1;
            if (!mack_ff)
            begin
              nxt_status = STS_DATA_NACK;
              nxt_state = ST_IGNORE;
            end
            else if (last_ff)
            begin
              nxt_status = STS_LAST_ACK;
              nxt_state = ST_IGNORE;
            end
            else
            begin
              nxt_status = STS_DATA_ACK;
              nxt_scl_oe_n = 1'b0;
              nxt_state = ST_WAIT;
            end
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------
  // sequencer flops
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_ZERO;
      shift_ff <= DATA_RST;
      sda_oe_n_ff <= 1'b1;
      scl_oe_n_ff <= 1'b1;
      status_ff <= STS_NONE;
      last_ff <= 1'b0;
      mack_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      sda_oe_n_ff <= nxt_sda_oe_n;
      scl_oe_n_ff <= nxt_scl_oe_n;
      status_ff <= nxt_status;
      last_ff <= nxt_last;
      mack_ff <= nxt_mack;
    end
  end
  // ----------------------------------------------------------
  // line synchronisers
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_m_ff <= 2'h3;
      pin_s_ff <= 2'h3;
      pin_d_ff <= 2'h3;
    end
    else
    begin
      pin_m_ff <= {scl_i, sda_i};
      pin_s_ff <= pin_m_ff;
      pin_d_ff <= pin_s_ff;
    end
  end
  // ----------------------------------------------------------
  // software registers
  // ----------------------------------------------------------
  // data written by software only, so a wake leaves what software stored
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_ff <= CTRL_RST;
      own_ff <= OWN_RST;
      data_ff <= DATA_RST;
      rdata_ff <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= {1'b0, wdata_i[CTRL_STEP-1:0]};
      if (wr_own)
        own_ff <= wdata_i;
      if (wr_data)
        data_ff <= wdata_i;
      if (rd_i)
        rdata_ff <= rd_mux;
    end
  end
  // ----------------------------------------------------------
  // step flag: a hardware set beats a same-cycle clear
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      step_ff <= 1'b0;
    else
      step_ff <= hw_set || (step_ff && !sw_clr);
  end
  // ----------------------------------------------------------
  // bus busy, start hand-off, wake and receiver flag
  // ----------------------------------------------------------
  // start request is only honoured when leaving a final state
  wire start_arm = sw_clr && step_ff && end_state && wdata_i[CTRL_START];
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      busy_ff <= 1'b0;
      start_pend_ff <= 1'b0;
      start_issue_ff <= 1'b0;
      wake_ff <= 1'b0;
      rx_mode_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= start_det || (busy_ff && !stop_det);
      start_issue_ff <= start_pend_ff && !busy_ff;
      start_pend_ff <= start_arm || (start_pend_ff && busy_ff);
      // wake held until software clears the step flag
      wake_ff <= (addr_done && match_w && sleep_i) || (wake_ff && !sw_clr);
      rx_mode_ff <= rx_enter || (rx_mode_ff && !start_det && !stop_det);
    end
  end
  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  // open-drain lines: only ever pull low
  assign rdata_o = rdata_ff;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = scl_oe_n_ff;
  assign sda_oe_n_o = sda_oe_n_ff;
  assign wake_o = wake_ff;
  assign start_issue_o = start_issue_ff;
  assign slave_rx_mode_o = rx_mode_ff;
  assign slave_tx_mode_o = (state_ff == ST_ADDR_ACK) || (state_ff == ST_WAIT) ||
                           (state_ff == ST_TX) || (state_ff == ST_TX_ACK);
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire ack_end = (state_ff == ST_TX_ACK) && scl_fall && iface_en && !start_det && !stop_det;
  wire aack_end = (state_ff == ST_ADDR_ACK) && scl_fall && iface_en && !start_det && !stop_det;
  own_read_sts_a: assert property (aack_end && !arb_lost_i |=> status_ff == STS_OWN_READ && step_ff)
    else $error("own read status wrong");
  arb_read_sts_a: assert property (aack_end && arb_lost_i |=> status_ff == STS_ARB_READ && step_ff)
    else $error("arbitration read status wrong");
  data_ack_sts_a: assert property (ack_end && mack_ff && !last_ff |=> status_ff == STS_DATA_ACK
                                    && state_ff == ST_WAIT)
    else $error("data ack status wrong");
  data_nack_sts_a: assert property (ack_end && !mack_ff |=> status_ff == STS_DATA_NACK && state_ff == ST_IGNORE)
    else $error("nack status wrong");
  last_ack_sts_a: assert property (ack_end && mack_ff && last_ff |=> status_ff == STS_LAST_ACK
                                    && state_ff == ST_IGNORE)
    else $error("last ack status wrong");
  ack_off_quiet_a: assert property (addr_done && !ack_en && !start_det && !stop_det
                                     |=> sda_oe_n_o ##1 sda_oe_n_o)
    else $error("address answered with ack disabled");
  gc_gate_a: assert property (addr_done && iface_en && !start_det && !stop_det && (shift_ff[7:1] == GEN_CALL_ADDR)
                               && (own_ff[7:1] != GEN_CALL_ADDR) && !own_ff[OWN_GCE] |=> sda_oe_n_o
                               && state_ff == ST_IGNORE)
    else $error("general call matched while disabled");
  scl_hold_a: assert property ((state_ff == ST_WAIT) && $past(state_ff == ST_WAIT) |-> !scl_oe_n_o)
    else $error("scl not held during wait");
  end_release_a: assert property ((state_ff == ST_IGNORE) && $past(state_ff == ST_IGNORE)
                                   |-> sda_oe_n_o)
    else $error("sda driven after final byte");
  final_mark_a: assert property ((state_ff == ST_WAIT) && sw_clr && step_ff && iface_en && !start_det && !stop_det
                                  && !wdata_i[CTRL_ACK] |=> last_ff && state_ff == ST_TX)
    else $error("final byte not marked");
  sleep_wake_a: assert property (addr_done && match_w && sleep_i |=> wake_o)
    else $error("no wake on sleep match");
  own_read_c: cover property (aack_end ##[1:40] (state_ff == ST_TX));
  data_ack_c: cover property (ack_end && mack_ff && !last_ff);
  data_nack_c: cover property (ack_end && !mack_ff);
  start_issue_c: cover property (start_issue_o);
endmodule

// ### dv/ist_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// master receiver on the two-wire bus
// ----------------------------------------
module ist_master_model
(
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // extra low time per bit, lets the bench run a slow master
  int unsigned stall_ns = 0;

  // 1 releases a line, the pull-up then wins
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // one bit: low phase, release, honour stretching, sample in high phase
  task automatic clk_bit(input logic b, output logic s);
    int n;
    #(40 + stall_ns);
    sda_o = b;
    #160;
    scl_o = 1'b1;
    n = 0;
    // bounded so a slave that never lets go cannot hang the model
    while (scl_i !== 1'b1 && n < 5000)
    begin
      #10;
      n++;
    end
    #60;
    s = sda_i;
    #60;
    scl_o = 1'b0;
  endtask

  // bus assumed idle high
  task automatic start_c();
    sda_o = 1'b0;
    #160;
    scl_o = 1'b0;
  endtask

  task automatic stop_c();
    #40;
    sda_o = 1'b0;
    #160;
    scl_o = 1'b1;
    #80;
    sda_o = 1'b1;
    #160;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, nack);
  endtask

  // acknowledge the byte when ack is set, not-acknowledge ends the read
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(!ack, s);
  endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ist_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic arb_lost_i = 1'b0;
  logic sleep_i = 1'b0;
  logic [7:0] rdata_o;
  logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, wake_o, start_issue_o, slave_tx_mode_o, slave_rx_mode_o;
  logic m_scl, m_sda, scl_w, sda_w, nk;
  int start_cnt = 0;
  logic [6:0] own;
  logic [7:0] got;
  int fail_count = 0;
  int check_count = 0;
  int n;

  // ----------------------------------------
  // clock, wires, design and far side
  // ----------------------------------------
  always #20 ref_clk_i = ~ref_clk_i;
  // open drain: any party pulling low wins
  assign scl_w = m_scl & (scl_oe_n_o | scl_o);
  assign sda_w = m_sda & (sda_oe_n_o | sda_o);
  // the start hand-off stands one cycle only, so count its pulses
  always @(posedge ref_clk_i)
    if (start_issue_o === 1'b1)
      start_cnt <= start_cnt + 1;

  ist_slave_tx uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .arb_lost_i(arb_lost_i), .sleep_i(sleep_i),
    .wake_o(wake_o), .start_issue_o(start_issue_o), .slave_tx_mode_o(slave_tx_mode_o),
    .slave_rx_mode_o(slave_rx_mode_o));
  ist_master_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));

  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rchk(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask

  function automatic logic [7:0] cv(input logic step, input logic ack, input logic sta);
    cv = 8'h00;
    cv[CTRL_STEP] = step;
    cv[CTRL_ACK] = ack;
    cv[CTRL_START] = sta;
    cv[CTRL_EN] = 1'b1;
  endfunction

  function automatic logic [7:0] after_byte(input logic last, input logic mack);
    after_byte = !mack ? STS_DATA_NACK : (last ? STS_LAST_ACK : STS_DATA_ACK);
  endfunction

  task automatic addr_ph(input logic [6:0] a, input logic rw, input logic ack);
    m.start_c();
    m.wr_byte({a, rw}, nk);
    chk({7'h00, nk}, {7'h00, !ack});
  endtask

  // wait for the slave to hold the clock low after a step
  task automatic stretch();
    int k;
    k = 0;
    while (scl_oe_n_o !== 1'b0 && k < 60)
    begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    chk({7'h00, scl_oe_n_o}, 8'h00);
  endtask

  task automatic xfer(input logic [7:0] d, input logic last, input logic mack);
    wr(REG_DATA, d);
    wr(REG_CTRL, cv(1'b1, !last, 1'b0));
    m.rd_byte(mack, got);
    chk(got, d);
    if (!last && mack)
      stretch();
    else
      repeat (8) @(posedge ref_clk_i);
    rchk(REG_STATUS, after_byte(last, mack));
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog well beyond the expected run of some 100 us
  initial
  begin
    #3000000;
    fail_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    void'($urandom(62));
    own = 7'($urandom_range(2, 126));
    rchk(REG_CTRL, CTRL_RST);
    rchk(REG_STATUS, STS_NONE);
    rchk(REG_DATA, DATA_RST);
    rchk(REG_OWN_ADDR, OWN_RST);
    wr(REG_OWN_ADDR, {own, 1'b0});
    rchk(REG_OWN_ADDR, {own, 1'b0});
    wr(REG_CTRL, cv(1'b0, 1'b1, 1'b0));
    $display("test regs done");
    addr_ph(own, 1'b1, 1'b1);
    stretch();
    rchk(REG_STATUS, STS_OWN_READ);
    chk({7'h00, slave_tx_mode_o}, 8'h01);
    rchk(REG_CTRL, cv(1'b1, 1'b1, 1'b0));
    xfer(8'($urandom), 1'b0, 1'b1);
    xfer(8'($urandom), 1'b1, 1'b0);
    wr(REG_CTRL, cv(1'b1, 1'b0, 1'b0));
    m.stop_c();
    addr_ph(own, 1'b1, 1'b0);
    m.stop_c();
    wr(REG_CTRL, cv(1'b1, 1'b1, 1'b0));
    addr_ph(own ^ 7'h01, 1'b1, 1'b0);
    m.stop_c();
    addr_ph(own, 1'b1, 1'b1);
    stretch();
    xfer(8'($urandom), 1'b1, 1'b1);
    m.rd_byte(1'b1, got);
    chk(got, 8'hff);
    wr(REG_CTRL, cv(1'b1, 1'b1, 1'b0));
    m.stop_c();
    $display("test final byte done");
    addr_ph(GEN_CALL_ADDR, 1'b1, 1'b0);
    m.stop_c();
    wr(REG_OWN_ADDR, {own, 1'b1});
    addr_ph(GEN_CALL_ADDR, 1'b1, 1'b1);
    stretch();
    xfer(8'($urandom), 1'b1, 1'b0);
    wr(REG_CTRL, cv(1'b1, 1'b1, 1'b0));
    m.stop_c();
    $display("test general call done");
    @(posedge ref_clk_i);
    arb_lost_i <= 1'b1;
    addr_ph(own, 1'b1, 1'b1);
    stretch();
    rchk(REG_STATUS, STS_ARB_READ);
    arb_lost_i <= 1'b0;
    xfer(8'($urandom), 1'b1, 1'b0);
    n = start_cnt;
    wr(REG_CTRL, cv(1'b1, 1'b1, 1'b1));
    repeat (10) @(posedge ref_clk_i);
    chk(8'(start_cnt - n), 8'h00);
    m.stop_c();
    repeat (10) @(posedge ref_clk_i);
    chk(8'(start_cnt - n), 8'h01);
    $display("test arbitration done");
    addr_ph(own, 1'b0, 1'b0);
    chk({7'h00, slave_rx_mode_o}, 8'h01);
    m.stop_c();
    @(posedge ref_clk_i);
    sleep_i <= 1'b1;
    addr_ph(own, 1'b1, 1'b1);
    stretch();
    repeat (20) @(posedge ref_clk_i);
    chk({6'h00, wake_o, scl_oe_n_o}, 8'h02);
    sleep_i <= 1'b0;
    xfer(8'($urandom), 1'b1, 1'b0);
    chk({7'h00, wake_o}, 8'h00);
    wr(REG_CTRL, cv(1'b1, 1'b1, 1'b0));
    m.stop_c();
    $display("test sleep done");
    for (int i = 0; i < 4; i++)
    begin
      n = 1 + ($urandom % 3);
      m.stall_ns = 400 * ($urandom % 2);
      addr_ph(own, 1'b1, 1'b1);
      stretch();
      for (int j = 0; j < n; j++)
        xfer(8'($urandom), j == n - 1, j != n - 1);
      wr(REG_CTRL, cv(1'b1, 1'b1, 1'b0));
      m.stop_c();
    end
    $display("test random done");
    report_and_stop();
  end
endmodule
